// ---- verilog/cgq_pkg.sv ----
// cgq_pkg: constants for the group, clock and integrity query command block.
// assumes a 250 MHz system clock and one byte-wide command and reply stream.
`default_nettype none
package cgq_pkg;
  // opcodes
  localparam logic [7:0] OP_LOOKUP = 8'h10;
  localparam logic [7:0] OP_CONFIG = 8'h11;
  localparam logic [7:0] OP_RAW_SECS = 8'h15;
  localparam logic [7:0] OP_ADJ_SECS = 8'h16;
  localparam logic [7:0] OP_CHECK_CRC = 8'h1D;
  // command status byte values
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_PIN = 8'h82;
  localparam logic [7:0] ST_NAME_LEN = 8'h85;
  localparam logic [7:0] ST_BAD_TYPE = 8'h8A;
  localparam logic [7:0] missing_group_code = 8'h8D;
  localparam logic [7:0] missing_object_code = 8'h8E;
  localparam logic [7:0] ST_BAD_CRC = 8'h97;
  localparam logic [7:0] ST_NOT_FOUND = 8'h98;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'hFF;
  // flag byte bit positions
  localparam int LOCKED_BIT = 0;
  localparam int PIN_CREATE_BIT = 1;
  // sizes
  localparam int MAX_NAME = 16;
  localparam int MAX_PIN = 8;
  localparam int MAX_GROUPS = 8;
  localparam int BUF_BYTES = 18;
  localparam int ADDR_W = 9;
  localparam int STORE_BYTES = 512;
  // group record layout, one 64-byte record per group
  localparam logic [5:0] REC_NAME = 6'h00;
  localparam logic [5:0] REC_NAME_LEN = 6'h10;
  localparam logic [5:0] REC_PIN_LEN = 6'h11;
  localparam logic [5:0] REC_PIN = 6'h12;
  localparam logic [5:0] REC_OBJ_CNT = 6'h1A;
  localparam logic [5:0] REC_OFS_ID = 6'h1B;
  localparam logic [5:0] REC_OFS_VAL = 6'h1C;
  localparam logic [5:0] REC_CRC_HI = 6'h3E;
  localparam logic [5:0] REC_CRC_LO = 6'h3F;
  // crc16, reflected polynomial
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // seconds clock
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int SUB_W = 28;
endpackage
`default_nettype wire

// ---- verilog/cgq_group_store.sv ----
// cgq_group_store: byte memory holding the transaction group records.
// assumes the loader and the reader sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module cgq_group_store (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [cgq_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port, data one cycle after the address
  input wire logic [cgq_pkg::ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:cgq_pkg::STORE_BYTES-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // cgq_group_store
`default_nettype wire

// ---- verilog/cgq_cmd_engine.sv ----
// cgq_cmd_engine: interpreter for group lookup, configuration, seconds clock and group crc commands.
// assumes the group store is loaded by other logic and the host frames each command with cmd_last.
`timescale 1ns/1ps
`default_nettype none
//Contract
//- group lookup carries a 1 to 16 byte name after the opcode and needs no PIN.
//- a found lookup answers status zero, length one and the group id, a failed one the code and length zero.
//- lookup names over sixteen bytes give 85H and unknown names give 98H.
//- configuration answers status zero and two bytes, group count then flag byte.
//- the flag byte ors bit 0 for locked and bit 1 for common PIN needed to create groups.
//- raw clock read answers status zero and the four whole-second bytes with no offset.
//- the seconds counter counts whole seconds since power first came and never stops; here rst clears it to zero.
//- on a valid adjusted read the offset is added to the seconds modulo 2^32 and four bytes returned.
//- adjusted read errors are 82H bad PIN, 8DH missing group, 8EH missing object, 8AH wrong object type.
//- the integrity check takes a group id and answers zero with no data on a match, 8DH for no group.
//- every group keeps a sixteen-bit crc that may be checked at any time.
//- the check recomputes the crc and answers 97H when it differs from the stored one.
//- group ids run from one upward, so a found lookup yields at least one.
module cgq_cmd_engine #(
  parameter int unsigned SEC_CYCLES = cgq_pkg::SEC_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command byte stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  output logic cmd_ready,
  // reply byte stream
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  input wire logic rsp_ready,
  // device state
  input wire logic [7:0] group_count_byte,
  input wire logic device_locked_flag,
  input wire logic create_needs_common_pin_flag,
  // group store loader
  input wire logic store_wr_en,
  input wire logic [cgq_pkg::ADDR_W-1:0] store_wr_addr,
  input wire logic [7:0] store_wr_data,
  // seconds clock
  output logic [31:0] seconds
);
  typedef enum logic [2:0] {CS_IDLE, CS_EXEC, CS_WAIT, CS_USE, CS_ANSWER, CS_REPLY} cgq_state_e;
  typedef enum logic [3:0] {RS_LK_LEN, RS_LK_NAME, RS_PIN_LEN, RS_PIN, RS_OBJ_CNT, RS_OFS_ID, RS_OFS_VAL,
    RS_CRC_DATA, RS_CRC_HI, RS_CRC_LO} cgq_step_e;
  typedef struct packed {
    cgq_state_e st;
    cgq_step_e step;
    logic [cgq_pkg::BUF_BYTES-1:0][7:0] cbuf;
    logic [4:0] nbytes;
    logic [2:0] grp;
    logic [5:0] idx;
    logic [15:0] crc;
    logic [31:0] acc;
    logic [7:0] status;
    logic [2:0] olen;
    logic [3:0][7:0] obuf;
    logic [2:0] pos;
    logic [cgq_pkg::ADDR_W-1:0] addr;
    logic [cgq_pkg::SUB_W-1:0] sub;
    logic [31:0] secs;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic rsp_last;
  } cgq_regs_s;

  cgq_regs_s q, d;
  logic [7:0] rd_data;

  localparam logic [cgq_pkg::SUB_W-1:0] SUB_LAST = cgq_pkg::SUB_W'(SEC_CYCLES - 1);

  function automatic logic [cgq_pkg::ADDR_W-1:0] rec_addr(input logic [2:0] g, input logic [5:0] off);
    return {g, off};
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ cgq_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  cgq_group_store u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(store_wr_en),
    .wr_addr(store_wr_addr),
    .wr_data(store_wr_data),
    .rd_addr(q.addr),
    .rd_data(rd_data)
  );

  // decoded command fields
  logic [7:0] opcode, arg_id, obj_id;
  logic [4:0] name_len, pin_len;
  logic [3:0] ngroups;
  logic gid_ok, last_grp;
  always_comb begin
    opcode = q.cbuf[0];
    arg_id = q.cbuf[1];
    obj_id = q.cbuf[q.nbytes - 5'h01];
    name_len = q.nbytes - 5'h01;
    pin_len = q.nbytes - 5'h03;
    ngroups = (group_count_byte > 8'(cgq_pkg::MAX_GROUPS)) ? 4'(cgq_pkg::MAX_GROUPS) : group_count_byte[3:0];
    gid_ok = (arg_id != 8'h00) && (arg_id <= {4'h0, ngroups});
    last_grp = ({1'b0, q.grp} + 4'h1) >= ngroups;
  end

  always_comb begin
    d = q;
    // free-running whole-second counter, wraps modulo 2^32
    if (q.sub == SUB_LAST) begin
      d.sub = '0;
      d.secs = q.secs + 32'h1;
    end else begin
      d.sub = q.sub + 1'b1;
    end
    case (q.st)
      CS_IDLE: begin
        // bytes past the buffer are counted but not kept, so long names still read as too long
        if (cmd_valid && q.cmd_ready) begin
          if (q.nbytes < 5'(cgq_pkg::BUF_BYTES)) begin
            d.cbuf[q.nbytes] = cmd_byte;
          end
          if (q.nbytes != 5'h1F) begin
            d.nbytes = q.nbytes + 5'h01;
          end
          if (cmd_last) begin
            d.cmd_ready = 1'b0;
            d.st = CS_EXEC;
          end
        end
      end
      CS_EXEC: begin
        d.status = cgq_pkg::ST_OK;
        d.olen = 3'h0;
        d.st = CS_ANSWER;
        d.grp = 3'h0;
        d.idx = 6'h0;
        case (opcode)
          cgq_pkg::OP_LOOKUP: begin
            if (name_len == 5'h00 || name_len > 5'(cgq_pkg::MAX_NAME)) begin
              d.status = cgq_pkg::ST_NAME_LEN;
            end else if (ngroups == 4'h0) begin
              d.status = cgq_pkg::ST_NOT_FOUND;
            end else begin
              d.step = RS_LK_LEN;
              d.addr = rec_addr(3'h0, cgq_pkg::REC_NAME_LEN);
              d.st = CS_WAIT;
            end
          end
          cgq_pkg::OP_CONFIG: begin
            d.olen = 3'h2;
            d.obuf[0] = group_count_byte;
            d.obuf[1] = '0;
            d.obuf[1][cgq_pkg::LOCKED_BIT] = device_locked_flag;
            d.obuf[1][cgq_pkg::PIN_CREATE_BIT] = create_needs_common_pin_flag;
          end
          cgq_pkg::OP_RAW_SECS: begin
            d.olen = 3'h4;
            d.obuf = {q.secs[7:0], q.secs[15:8], q.secs[23:16], q.secs[31:24]};
          end
          cgq_pkg::OP_ADJ_SECS: begin
            if (!gid_ok) begin
              d.status = cgq_pkg::missing_group_code;
            end else if (q.nbytes < 5'h04 || pin_len > 5'(cgq_pkg::MAX_PIN)) begin
              d.status = cgq_pkg::ST_BAD_PIN;
            end else begin
              d.grp = 3'(arg_id - 8'h01);
              d.step = RS_PIN_LEN;
              d.addr = rec_addr(3'(arg_id - 8'h01), cgq_pkg::REC_PIN_LEN);
              d.st = CS_WAIT;
            end
          end
          cgq_pkg::OP_CHECK_CRC: begin
            if (!gid_ok) begin
              d.status = cgq_pkg::missing_group_code;
            end else begin
              d.grp = 3'(arg_id - 8'h01);
              d.crc = cgq_pkg::CRC_INIT;
              d.step = RS_CRC_DATA;
              d.addr = rec_addr(3'(arg_id - 8'h01), cgq_pkg::REC_NAME);
              d.st = CS_WAIT;
            end
          end
          default: begin
            d.status = cgq_pkg::ST_UNKNOWN_CMD;
          end
        endcase
      end
      CS_WAIT: begin
        d.st = CS_USE;
      end
      CS_USE: begin
        d.st = CS_WAIT;
        case (q.step)
          RS_LK_LEN, RS_LK_NAME: begin
            if ((q.step == RS_LK_LEN) ? (rd_data == {3'h0, name_len}) : (rd_data == q.cbuf[q.idx + 6'h01])) begin
              if (q.step == RS_LK_NAME && q.idx == 6'(name_len - 5'h01)) begin
                d.olen = 3'h1;
                d.obuf[0] = {5'h00, q.grp} + 8'h01;
                d.st = CS_ANSWER;
              end else begin
                d.idx = (q.step == RS_LK_LEN) ? 6'h0 : q.idx + 6'h01;
                d.step = RS_LK_NAME;
                d.addr = rec_addr(q.grp, cgq_pkg::REC_NAME + d.idx);
              end
            end else if (last_grp) begin
              d.status = cgq_pkg::ST_NOT_FOUND;
              d.st = CS_ANSWER;
            end else begin
              d.grp = q.grp + 3'h1;
              d.step = RS_LK_LEN;
              d.addr = rec_addr(q.grp + 3'h1, cgq_pkg::REC_NAME_LEN);
            end
          end
          RS_PIN_LEN, RS_PIN: begin
            if ((q.step == RS_PIN_LEN) ? (rd_data != {3'h0, pin_len}) : (rd_data != q.cbuf[q.idx + 6'h02])) begin
              d.status = cgq_pkg::ST_BAD_PIN;
              d.st = CS_ANSWER;
            end else if (q.step == RS_PIN && q.idx == 6'(pin_len - 5'h01)) begin
              d.step = RS_OBJ_CNT;
              d.addr = rec_addr(q.grp, cgq_pkg::REC_OBJ_CNT);
            end else begin
              d.idx = (q.step == RS_PIN_LEN) ? 6'h0 : q.idx + 6'h01;
              d.step = RS_PIN;
              d.addr = rec_addr(q.grp, cgq_pkg::REC_PIN + d.idx);
            end
          end
          RS_OBJ_CNT: begin
            if (obj_id == 8'h00 || obj_id > rd_data) begin
              d.status = cgq_pkg::missing_object_code;
              d.st = CS_ANSWER;
            end else begin
              d.step = RS_OFS_ID;
              d.addr = rec_addr(q.grp, cgq_pkg::REC_OFS_ID);
            end
          end
          RS_OFS_ID: begin
            if (obj_id != rd_data) begin
              d.status = cgq_pkg::ST_BAD_TYPE;
              d.st = CS_ANSWER;
            end else begin
              d.idx = 6'h0;
              d.step = RS_OFS_VAL;
              d.addr = rec_addr(q.grp, cgq_pkg::REC_OFS_VAL);
            end
          end
          RS_OFS_VAL: begin
            d.acc = {q.acc[23:0], rd_data};
            if (q.idx == 6'h3) begin
              // sum taken against the live counter, wrapping in 32 bits
              d.olen = 3'h4;
              {d.obuf[0], d.obuf[1], d.obuf[2], d.obuf[3]} = d.acc + q.secs;
              d.st = CS_ANSWER;
            end else begin
              d.idx = q.idx + 6'h01;
              d.addr = rec_addr(q.grp, cgq_pkg::REC_OFS_VAL + d.idx);
            end
          end
          RS_CRC_DATA: begin
            d.crc = crc16_byte(q.crc, rd_data);
            if (q.idx == 6'(cgq_pkg::REC_CRC_HI - 6'h01)) begin
              d.step = RS_CRC_HI;
              d.addr = rec_addr(q.grp, cgq_pkg::REC_CRC_HI);
            end else begin
              d.idx = q.idx + 6'h01;
              d.addr = rec_addr(q.grp, d.idx);
            end
          end
          RS_CRC_HI: begin
            if (rd_data != q.crc[15:8]) begin
              d.status = cgq_pkg::ST_BAD_CRC;
            end
            d.step = RS_CRC_LO;
            d.addr = rec_addr(q.grp, cgq_pkg::REC_CRC_LO);
          end
          RS_CRC_LO: begin
            if (rd_data != q.crc[7:0]) begin
              d.status = cgq_pkg::ST_BAD_CRC;
            end
            d.st = CS_ANSWER;
          end
          default: begin
            d.st = CS_ANSWER;
          end
        endcase
      end
      CS_ANSWER: begin
        // failed commands never carry data
        if (q.status != cgq_pkg::ST_OK) begin
          d.olen = 3'h0;
        end
        d.rsp_valid = 1'b1;
        d.rsp_byte = q.status;
        d.rsp_last = 1'b0;
        d.pos = 3'h0;
        d.st = CS_REPLY;
      end
      CS_REPLY: begin
        // the byte on show only moves on when the host takes it
        if (rsp_ready) begin
          d.pos = q.pos + 3'h1;
          if (q.rsp_last) begin
            d.rsp_valid = 1'b0;
            d.rsp_last = 1'b0;
            d.nbytes = 5'h00;
            d.cmd_ready = 1'b1;
            d.st = CS_IDLE;
          end else if (q.pos == 3'h0) begin
            d.rsp_byte = {5'h00, q.olen};
            d.rsp_last = (q.olen == 3'h0);
          end else begin
            d.rsp_byte = q.obuf[2'(q.pos - 3'h1)];
            d.rsp_last = (q.pos == q.olen);
          end
        end
      end
      default: begin
        d.st = CS_IDLE;
      end
    endcase
  end

  localparam cgq_regs_s RST_VAL = '{st: CS_IDLE, step: RS_LK_LEN, cmd_ready: 1'b1, default: '0};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready = q.cmd_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_byte = q.rsp_byte;
  assign rsp_last = q.rsp_last;
  assign seconds = q.secs;

  // reply framing: status, then length, then the data
  sequence s_status_taken;
    rsp_valid && rsp_ready && (q.pos == 3'h0);
  endsequence
  sequence s_length_shown;
    rsp_valid && (rsp_byte == {5'h00, q.olen}) && (rsp_last == (q.olen == 3'h0));
  endsequence
  a_len_follows: assert property (@(posedge clk_sys) disable iff (rst)
    s_status_taken |=> s_length_shown) else $error("length byte did not follow the status byte");
  a_reply_hold: assert property (@(posedge clk_sys) disable iff (rst)
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(rsp_last))
    else $error("reply byte changed while the host held off");
  a_ready_idle: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_ready |-> (q.st == CS_IDLE)) else $error("command accepted outside idle");
  a_secs_tick: assert property (@(posedge clk_sys) disable iff (rst)
    (q.sub == SUB_LAST) |=> (seconds == $past(seconds) + 32'h1)) else $error("seconds counter missed a tick");
  a_secs_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (q.sub != SUB_LAST) |=> $stable(seconds)) else $error("seconds counter moved between ticks");
  a_lookup_id: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == CS_ANSWER) && (opcode == cgq_pkg::OP_LOOKUP) && (q.status == cgq_pkg::ST_OK) |->
      (q.olen == 3'h1) && (q.obuf[0] != 8'h00)) else $error("found group answered without a valid id");
  a_config_len: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == CS_ANSWER) && (opcode == cgq_pkg::OP_CONFIG) |-> (q.status == cgq_pkg::ST_OK) && (q.olen == 3'h2))
    else $error("configuration answer not two bytes with zero status");
endmodule // cgq_cmd_engine
`default_nettype wire

// ---- bench/cgq_host_model.sv ----
// cgq_host_model: host that frames commands and gathers the replies.
// assumes valid/ready byte streams sampled at clk_sys rising edges.
`timescale 1ns/1ps
`default_nettype none
module cgq_host_model (
  // clock
  input wire logic clk_sys,
  // command stream
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_last,
  input wire logic cmd_ready,
  // reply stream
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  output logic rsp_ready,
  // status
  output logic hung
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cmd_last = 1'b0;
    rsp_ready = 1'b0;
    hung = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd[$], input bit slow, output logic [7:0] rsp[$], output bit last_ok);
    int n;
    rsp = {};
    last_ok = 1'b0;
    foreach (cmd[i]) begin
      cmd_valid <= 1'b1;
      cmd_byte <= cmd[i];
      cmd_last <= (i == cmd.size() - 1);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (cmd_ready !== 1'b1 && n < 200);
      if (n >= 200) hung = 1'b1;
    end
    // released data is inverted so a stale byte never looks valid
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
    cmd_byte <= ~cmd[cmd.size() - 1];
    rsp_ready <= 1'b1;
    for (n = 0; n < 400 && !last_ok; n++) begin
      @(posedge clk_sys);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        rsp.push_back(rsp_byte);
        last_ok = (rsp_last === 1'b1);
      end
      if (!last_ok) rsp_ready <= slow ? ~rsp_ready : 1'b1;
    end
    rsp_ready <= 1'b0;
    if (!last_ok) hung = 1'b1;
  endtask
endmodule // cgq_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// tb_top: directed tests of the lookup, configuration, clock and crc commands.
// assumes group g occupies store bytes (g-1)*64 up, multi-byte values go high byte first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned SC = 2000;
  logic clk_sys, rst, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready, hung;
  logic [7:0] cmd_byte, rsp_byte, group_count_byte, store_wr_data;
  logic device_locked_flag, create_needs_common_pin_flag, store_wr_en;
  logic [cgq_pkg::ADDR_W-1:0] store_wr_addr;
  logic [31:0] seconds;
  int unsigned cyc;
  int err_total, n_checks;
  logic [7:0] nm1[$], nm2[$], pn1[$], pn2[$], tmp[$];

  cgq_cmd_engine #(.SEC_CYCLES(SC)) dut_u (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_last(rsp_last), .rsp_ready(rsp_ready), .group_count_byte(group_count_byte),
    .device_locked_flag(device_locked_flag), .create_needs_common_pin_flag(create_needs_common_pin_flag),
    .store_wr_en(store_wr_en), .store_wr_addr(store_wr_addr), .store_wr_data(store_wr_data),
    .seconds(seconds));
  cgq_host_model host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
    .rsp_ready(rsp_ready), .hung(hung));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rst) cyc <= 0;
    else cyc <= cyc + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input logic [7:0] cmd[$], input logic [7:0] exp[$], input bit slow);
    logic [7:0] rsp[$];
    bit last_ok;
    host_u.xfer(cmd, slow, rsp, last_ok);
    if (hung === 1'b1) begin
      err_total++;
      end_sim();
    end else begin
      check(rsp.size(), exp.size());
      foreach (exp[i]) if (i < rsp.size()) check(rsp[i], exp[i]);
      check(last_ok, 1'b1);
    end
  endtask
  task automatic wr_store(input int a, input logic [7:0] d);
    @(posedge clk_sys);
    store_wr_en <= 1'b1;
    store_wr_addr <= a[cgq_pkg::ADDR_W-1:0];
    store_wr_data <= d;
    @(posedge clk_sys);
    store_wr_en <= 1'b0;
  endtask
  // object 1 is the clock offset, object 2 some other kind
  task automatic load_group(input int g, input logic [7:0] nm[$], input logic [7:0] pn[$], input logic [31:0] ofs);
    logic [7:0] rec[64];
    logic [15:0] crc;
    rec = '{default: 8'h00};
    foreach (nm[i]) rec[cgq_pkg::REC_NAME + i] = nm[i];
    foreach (pn[i]) rec[cgq_pkg::REC_PIN + i] = pn[i];
    rec[cgq_pkg::REC_NAME_LEN] = 8'(nm.size());
    rec[cgq_pkg::REC_PIN_LEN] = 8'(pn.size());
    rec[cgq_pkg::REC_OBJ_CNT] = 8'h02;
    rec[cgq_pkg::REC_OFS_ID] = 8'h01;
    for (int i = 0; i < 4; i++) rec[cgq_pkg::REC_OFS_VAL + i] = ofs[31 - 8 * i -: 8];
    crc = cgq_pkg::CRC_INIT;
    for (int i = 0; i < 62; i++) begin
      crc = crc ^ {8'h00, rec[i]};
      for (int b = 0; b < 8; b++) crc = crc[0] ? ((crc >> 1) ^ cgq_pkg::CRC_POLY) : (crc >> 1);
    end
    rec[cgq_pkg::REC_CRC_HI] = crc[15:8];
    rec[cgq_pkg::REC_CRC_LO] = crc[7:0];
    for (int i = 0; i < 64; i++) wr_store((g - 1) * 64 + i, rec[i]);
  endtask
  // sample a quarter into the second, well clear of the tick
  task automatic wait_sec(input int unsigned k);
    int n;
    n = 0;
    while (cyc != k * SC + SC / 4 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    check(n < 20000, 1'b1);
    if (n >= 20000) end_sim();
    check(seconds, k);
  endtask

  initial begin
    rst <= 1'b1;
    group_count_byte <= 8'h02;
    device_locked_flag <= 1'b0;
    create_needs_common_pin_flag <= 1'b0;
    store_wr_en <= 1'b0;
    store_wr_addr <= '0;
    store_wr_data <= 8'h00;
    err_total = 0;
    n_checks = 0;
    nm1 = {8'h41, 8'h42};
    pn1 = {8'h11, 8'h22};
    for (int i = 0; i < 16; i++) nm2.push_back(8'h30 + i);
    for (int i = 0; i < 8; i++) pn2.push_back(8'hA0 + i);
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    load_group(1, nm1, pn1, 32'h0000_0010);
    load_group(2, nm2, pn2, 32'hFFFF_FFFE);
    for (int i = 0; i < 4; i++) begin
      device_locked_flag <= i[0];
      create_needs_common_pin_flag <= i[1];
      @(posedge clk_sys);
      run({cgq_pkg::OP_CONFIG}, {cgq_pkg::ST_OK, 8'h02, 8'h02, 8'(i[1:0])}, i[0]);
    end
    $display("test configuration done");
    run({cgq_pkg::OP_LOOKUP, nm2}, {cgq_pkg::ST_OK, 8'h01, 8'h02}, 1'b1);
    run({cgq_pkg::OP_LOOKUP, nm1}, {cgq_pkg::ST_OK, 8'h01, 8'h01}, 1'b0);
    run({cgq_pkg::OP_LOOKUP, 8'h41}, {cgq_pkg::ST_NOT_FOUND, 8'h00}, 1'b0);
    run({cgq_pkg::OP_LOOKUP, nm2, 8'h40}, {cgq_pkg::ST_NAME_LEN, 8'h00}, 1'b0);
    run({8'h17}, {cgq_pkg::ST_UNKNOWN_CMD, 8'h00}, 1'b1);
    $display("test lookup done");
    wait_sec(1);
    run({cgq_pkg::OP_RAW_SECS}, {cgq_pkg::ST_OK, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
    $display("test raw seconds done");
    wait_sec(3);
    // 3 + FFFFFFFE wraps to 1
    run({cgq_pkg::OP_ADJ_SECS, 8'h02, pn2, 8'h01}, {cgq_pkg::ST_OK, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    run({cgq_pkg::OP_ADJ_SECS, 8'h01, pn1, 8'h01}, {cgq_pkg::ST_OK, 8'h04, 8'h00, 8'h00, 8'h00, 8'h13}, 1'b1);
    tmp = pn2;
    tmp[7] = 8'h00;
    run({cgq_pkg::OP_ADJ_SECS, 8'h02, tmp, 8'h01}, {cgq_pkg::ST_BAD_PIN, 8'h00}, 1'b0);
    run({cgq_pkg::OP_ADJ_SECS, 8'h03, pn1, 8'h01}, {cgq_pkg::missing_group_code, 8'h00}, 1'b0);
    run({cgq_pkg::OP_ADJ_SECS, 8'h01, pn1, 8'h03}, {cgq_pkg::missing_object_code, 8'h00}, 1'b0);
    run({cgq_pkg::OP_ADJ_SECS, 8'h01, pn1, 8'h02}, {cgq_pkg::ST_BAD_TYPE, 8'h00}, 1'b0);
    $display("test adjusted seconds done");
    run({cgq_pkg::OP_CHECK_CRC, 8'h01}, {cgq_pkg::ST_OK, 8'h00}, 1'b0);
    run({cgq_pkg::OP_CHECK_CRC, 8'h03}, {cgq_pkg::missing_group_code, 8'h00}, 1'b0);
    run({cgq_pkg::OP_CHECK_CRC, 8'h00}, {cgq_pkg::missing_group_code, 8'h00}, 1'b1);
    wr_store(8'h30, 8'h5A);
    run({cgq_pkg::OP_CHECK_CRC, 8'h01}, {cgq_pkg::ST_BAD_CRC, 8'h00}, 1'b0);
    run({cgq_pkg::OP_CHECK_CRC, 8'h02}, {cgq_pkg::ST_OK, 8'h00}, 1'b0);
    $display("test integrity done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
